/* pkg/tbls_pkg.sv */
// Constants, field layout and types shared by the transmit line-setup block
`default_nettype none
package tbls_pkg;
  localparam int NUM_CH = 8;
  localparam int DLY_W = 13;
  localparam int START_W = 10;
  localparam int LN_W = 11;
  localparam int LT_W = 7;
  localparam int CYC_W = 8;
  localparam int PAT_AW = 13;
  localparam int PAT_SHIFT = PAT_AW - START_W;
  localparam int PAYLOAD_W = 200;
  localparam int BYTE_CNT_W = 5;
  localparam int BIT_CNT_W = 3;

  // Register addresses of the three line commands
  localparam logic [6:0] ADDR_LINE1 = 7'h10;
  localparam logic [6:0] ADDR_LINE2 = 7'h11;
  localparam logic [6:0] ADDR_LINE3 = 7'h12;
  localparam int RW_BIT = 7;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;

  // Whole command lengths in bytes, address byte included
  localparam logic [BYTE_CNT_W-1:0] LEN_LINE1 = 5'h04;
  localparam logic [BYTE_CNT_W-1:0] LEN_LINE2 = 5'h1A;
  localparam logic [BYTE_CNT_W-1:0] LEN_LINE3 = 5'h14;

  // Payload bit positions, counted from the last bit received
  localparam int C1_LN_LSB = 8;
  localparam int C1_LT_LSB = 1;
  localparam int C1_INV = 0;
  localparam int C2_LT_LSB = 193;
  localparam int C2_INV = 192;
  localparam int C2_GRP_TOP = 191;
  localparam int C2_GRP_W = 24;
  localparam int G2_DLY_LSB = 11;
  localparam int G2_ADD_LSB = 1;
  localparam int G2_RX = 0;
  localparam int C3_LT_LSB = 145;
  localparam int C3_INV = 144;
  localparam int C3_ADD_LSB = 128;
  localparam int C3_GRP_TOP = 127;
  localparam int C3_GRP_W = 16;
  localparam int G3_DLY_LSB = 2;
  localparam int G3_RX = 1;
  localparam int G3_TX = 0;

  // Pattern sample bits: positive drive high, negative drive low
  localparam int SMP_POS = 1;
  localparam int SMP_NEG = 0;
  localparam logic [1:0] SAMPLE_EOP = 2'h3;

  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_LINE1 = 2'b01,
    CMD_LINE2 = 2'b10,
    CMD_LINE3 = 2'b11
  } tbls_cmd_e;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_WAIT = 2'b01,
    CH_PLAY = 2'b10,
    CH_DONE = 2'b11
  } tbls_ch_state_e;

  // Typical pulser current, one-hot
  typedef enum logic [3:0] {
    CUR_2A10 = 4'b0001,
    CUR_1A75 = 4'b0010,
    CUR_0A70 = 4'b0100,
    CUR_0A35 = 4'b1000
  } tbls_current_e;

  typedef struct packed {
    logic [DLY_W-1:0] channel_delay;
    logic [START_W-1:0] pattern_start_address;
    logic rx_en;
    logic tx_en;
  } tbls_chan_cfg_s;

  typedef struct packed {
    logic [DLY_W-1:0] channel_delay;
    logic [START_W-1:0] pattern_start_address;
  } tbls_ln_entry_s;

  typedef struct packed {
    logic [CYC_W-1:0] cycles;
    logic continuous_wave_mode;
    logic drive_strength_sel_hi;
    logic drive_strength_sel_lo;
  } tbls_lt_entry_s;

  typedef struct packed {
    logic pos;
    logic neg;
    logic clamp;
    logic rx_on;
  } tbls_drive_s;
endpackage
`default_nettype wire

/* hw/tbls_line_setup.sv */
// Line-setup command decoder and per-channel pattern playback
`timescale 1ns/10ps
`default_nettype none

module tbls_line_setup #(
  parameter int NUM_CH = tbls_pkg::NUM_CH,
  parameter logic [6:0] ADDR_LINE1 = tbls_pkg::ADDR_LINE1,
  parameter logic [6:0] ADDR_LINE2 = tbls_pkg::ADDR_LINE2,
  parameter logic [6:0] ADDR_LINE3 = tbls_pkg::ADDR_LINE3
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic fire_strobe,
  input wire logic five_level,
  input wire tbls_pkg::tbls_ln_entry_s [NUM_CH-1:0] ln_data,
  input wire tbls_pkg::tbls_lt_entry_s lt_data,
  input wire logic [NUM_CH-1:0][1:0] pat_sample,
  output logic [tbls_pkg::LN_W-1:0] line_number_pointer_reg,
  output logic [tbls_pkg::LT_W-1:0] line_type_pointer_reg,
  output logic [NUM_CH-1:0][tbls_pkg::PAT_AW-1:0] pat_addr_reg,
  output var tbls_pkg::tbls_drive_s [NUM_CH-1:0] ch_drive_reg,
  output var tbls_pkg::tbls_current_e current_level_reg,
  output logic tx_busy_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [tbls_pkg::BYTE_CNT_W-1:0] cmd_len(input tbls_pkg::tbls_cmd_e c);
    if (c == tbls_pkg::CMD_LINE1) begin
      return tbls_pkg::LEN_LINE1;
    end else if (c == tbls_pkg::CMD_LINE2) begin
      return tbls_pkg::LEN_LINE2;
    end else if (c == tbls_pkg::CMD_LINE3) begin
      return tbls_pkg::LEN_LINE3;
    end
    return '0;
  endfunction

  function automatic logic is_eop(input logic [1:0] s);
    return s == tbls_pkg::SAMPLE_EOP;
  endfunction

  function automatic tbls_pkg::tbls_chan_cfg_s grp2(input logic [tbls_pkg::PAYLOAD_W-1:0] p,
                                                   input int k);
    logic [tbls_pkg::C2_GRP_W-1:0] g;
    tbls_pkg::tbls_chan_cfg_s r;
    g = p[tbls_pkg::C2_GRP_TOP - k * tbls_pkg::C2_GRP_W -: tbls_pkg::C2_GRP_W];
    r.channel_delay = g[tbls_pkg::G2_DLY_LSB +: tbls_pkg::DLY_W];
    r.pattern_start_address = g[tbls_pkg::G2_ADD_LSB +: tbls_pkg::START_W];
    r.rx_en = g[tbls_pkg::G2_RX];
    r.tx_en = 1'b1;
    return r;
  endfunction

  function automatic tbls_pkg::tbls_chan_cfg_s grp3(input logic [tbls_pkg::PAYLOAD_W-1:0] p,
                                                   input int k);
    logic [tbls_pkg::C3_GRP_W-1:0] g;
    tbls_pkg::tbls_chan_cfg_s r;
    g = p[tbls_pkg::C3_GRP_TOP - k * tbls_pkg::C3_GRP_W -: tbls_pkg::C3_GRP_W];
    r.channel_delay = g[tbls_pkg::G3_DLY_LSB +: tbls_pkg::DLY_W];
    r.pattern_start_address = p[tbls_pkg::C3_ADD_LSB +: tbls_pkg::START_W];
    r.rx_en = g[tbls_pkg::G3_RX];
    r.tx_en = g[tbls_pkg::G3_TX];
    return r;
  endfunction

  function automatic logic [tbls_pkg::PAT_AW-1:0] start_addr(input tbls_pkg::tbls_chan_cfg_s c);
    return {c.pattern_start_address, {tbls_pkg::PAT_SHIFT{1'b0}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection

  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic cs_s1_reg, cs_s2_reg;
  logic mosi_s1_reg, mosi_s2_reg;
  logic fire_s1_reg, fire_s2_reg, fire_s3_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= 3'h0;
      {cs_s1_reg, cs_s2_reg} <= 2'h3;
      {mosi_s1_reg, mosi_s2_reg} <= 2'h0;
      {fire_s1_reg, fire_s2_reg, fire_s3_reg} <= 3'h0;
    end else begin
      {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= {spi_sclk, sclk_s1_reg, sclk_s2_reg};
      {cs_s1_reg, cs_s2_reg} <= {spi_cs_n, cs_s1_reg};
      {mosi_s1_reg, mosi_s2_reg} <= {spi_mosi, mosi_s1_reg};
      {fire_s1_reg, fire_s2_reg, fire_s3_reg} <= {fire_strobe, fire_s1_reg, fire_s2_reg};
    end
  end

  wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  wire fire_rise = fire_s2_reg & ~fire_s3_reg;
  wire fire_on = fire_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Command byte reception

  logic [tbls_pkg::PAYLOAD_W-1:0] payload_reg;
  logic [tbls_pkg::BIT_CNT_W-1:0] bit_cnt_reg;
  logic [tbls_pkg::BYTE_CNT_W-1:0] byte_cnt_reg;
  logic [7:0] addr_byte_reg;
  tbls_pkg::tbls_cmd_e cmd_reg, apply_cmd_reg;
  logic apply_reg, fetch_reg;

  wire byte_done = sclk_rise & (bit_cnt_reg == tbls_pkg::LAST_BIT);
  wire [7:0] byte_in = {payload_reg[6:0], mosi_s2_reg};
  wire [tbls_pkg::BYTE_CNT_W-1:0] byte_cnt_inc = byte_cnt_reg + 1'b1;
  wire wr_ok = ~byte_in[tbls_pkg::RW_BIT];
  wire tbls_pkg::tbls_cmd_e cmd_dec =
    (wr_ok && byte_in[6:0] == ADDR_LINE1) ? tbls_pkg::CMD_LINE1 :
    (wr_ok && byte_in[6:0] == ADDR_LINE2) ? tbls_pkg::CMD_LINE2 :
    (wr_ok && byte_in[6:0] == ADDR_LINE3) ? tbls_pkg::CMD_LINE3 : tbls_pkg::CMD_NONE;
  wire first_byte = byte_done & (byte_cnt_reg == '0);
  wire cmd_complete = byte_done & (cmd_reg != tbls_pkg::CMD_NONE)
                      & (byte_cnt_inc == cmd_len(cmd_reg));

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      payload_reg <= '0;
      bit_cnt_reg <= '0;
      byte_cnt_reg <= '0;
      addr_byte_reg <= '0;
      cmd_reg <= tbls_pkg::CMD_NONE;
      apply_cmd_reg <= tbls_pkg::CMD_NONE;
      apply_reg <= 1'b0;
    end else begin
      apply_reg <= cmd_complete;
      if (cmd_complete) begin
        apply_cmd_reg <= cmd_reg;
      end
      if (cs_s2_reg) begin
        bit_cnt_reg <= '0;
        byte_cnt_reg <= '0;
        cmd_reg <= tbls_pkg::CMD_NONE;
      end else if (sclk_rise) begin
        payload_reg <= {payload_reg[tbls_pkg::PAYLOAD_W-2:0], mosi_s2_reg};
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
        if (byte_done) begin
          byte_cnt_reg <= byte_cnt_inc;
        end
        if (first_byte) begin
          addr_byte_reg <= byte_in;
          cmd_reg <= cmd_dec;
        end else if (cmd_complete) begin
          cmd_reg <= tbls_pkg::CMD_NONE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applying a received command

  tbls_pkg::tbls_chan_cfg_s [NUM_CH-1:0] cfg_reg;
  tbls_pkg::tbls_lt_entry_s lt_cfg_reg;
  logic inv_reg;
  tbls_pkg::tbls_cmd_e fetch_cmd_reg;

  wire line_ext2 = apply_cmd_reg == tbls_pkg::CMD_LINE2;
  wire line_ext3 = apply_cmd_reg == tbls_pkg::CMD_LINE3;
  wire [tbls_pkg::LT_W-1:0] lt_field =
    line_ext2 ? payload_reg[tbls_pkg::C2_LT_LSB +: tbls_pkg::LT_W] :
    line_ext3 ? payload_reg[tbls_pkg::C3_LT_LSB +: tbls_pkg::LT_W] :
                payload_reg[tbls_pkg::C1_LT_LSB +: tbls_pkg::LT_W];
  wire inv_field = line_ext2 ? payload_reg[tbls_pkg::C2_INV] :
                   line_ext3 ? payload_reg[tbls_pkg::C3_INV] : payload_reg[tbls_pkg::C1_INV];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      line_number_pointer_reg <= '0;
      line_type_pointer_reg <= '0;
      inv_reg <= 1'b0;
      fetch_reg <= 1'b0;
      fetch_cmd_reg <= tbls_pkg::CMD_NONE;
      cfg_reg <= '0;
      lt_cfg_reg <= '0;
    end else begin
      fetch_reg <= apply_reg;
      if (apply_reg) begin
        fetch_cmd_reg <= apply_cmd_reg;
        line_type_pointer_reg <= lt_field;
        inv_reg <= inv_field;
        if (apply_cmd_reg == tbls_pkg::CMD_LINE1) begin
          line_number_pointer_reg <= payload_reg[tbls_pkg::C1_LN_LSB +: tbls_pkg::LN_W];
        end
        for (int k = 0; k < NUM_CH; k++) begin
          if (line_ext2) begin
            cfg_reg[k] <= grp2(payload_reg, k);
          end else if (line_ext3) begin
            cfg_reg[k] <= grp3(payload_reg, k);
          end
        end
      end
      if (fetch_reg) begin
        lt_cfg_reg <= lt_data;
        if (fetch_cmd_reg == tbls_pkg::CMD_LINE1) begin
          for (int k = 0; k < NUM_CH; k++) begin
            cfg_reg[k] <= {ln_data[k], 1'b1, 1'b1};
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive-strength decode

  wire tbls_pkg::tbls_current_e current_dec =
    ({lt_cfg_reg.drive_strength_sel_hi, lt_cfg_reg.drive_strength_sel_lo} == 2'h0) ?
      tbls_pkg::CUR_2A10 :
    ({lt_cfg_reg.drive_strength_sel_hi, lt_cfg_reg.drive_strength_sel_lo} == 2'h1) ?
      tbls_pkg::CUR_1A75 :
    ({lt_cfg_reg.drive_strength_sel_hi, lt_cfg_reg.drive_strength_sel_lo} == 2'h2) ?
      tbls_pkg::CUR_0A70 : tbls_pkg::CUR_0A35;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel playback

  tbls_pkg::tbls_ch_state_e [NUM_CH-1:0] st_reg;
  logic [NUM_CH-1:0][tbls_pkg::DLY_W-1:0] dly_cnt_reg;
  logic [NUM_CH-1:0][tbls_pkg::CYC_W-1:0] cyc_cnt_reg;
  logic [NUM_CH-1:0] eop_ch;
  logic [NUM_CH-1:0] last_cyc;
  logic [NUM_CH-1:0] playing;
  tbls_pkg::tbls_drive_s [NUM_CH-1:0] drive_next;

  for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
    localparam int PAIR = k % (NUM_CH / 2);
    wire [1:0] smp = inv_reg ? {pat_sample[k][tbls_pkg::SMP_NEG], pat_sample[k][tbls_pkg::SMP_POS]}
                             : pat_sample[k];
    wire drv_pos = smp[tbls_pkg::SMP_POS] & cfg_reg[k].tx_en;
    wire drv_neg = smp[tbls_pkg::SMP_NEG] & cfg_reg[k].tx_en;
    assign eop_ch[k] = five_level ? is_eop(pat_sample[PAIR]) : is_eop(pat_sample[k]);
    assign last_cyc[k] = (cyc_cnt_reg[k] + 1'b1 == lt_cfg_reg.cycles)
                         & ~lt_cfg_reg.continuous_wave_mode;
    assign playing[k] = (st_reg[k] == tbls_pkg::CH_PLAY) & fire_on & ~eop_ch[k];
    // sample decode, end symbol held back
    assign drive_next[k] = playing[k] ? '{pos: drv_pos, neg: drv_neg,
                                          clamp: ~(drv_pos | drv_neg), rx_on: 1'b0}
                                      : '{pos: 1'b0, neg: 1'b0, clamp: 1'b1,
                                          rx_on: cfg_reg[k].rx_en};
  end

  // each channel steps on its own
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg <= {NUM_CH{tbls_pkg::CH_IDLE}};
      dly_cnt_reg <= '0;
      cyc_cnt_reg <= '0;
      pat_addr_reg <= '0;
      ch_drive_reg <= {NUM_CH{4'h2}};
    end else begin
      ch_drive_reg <= drive_next;
      for (int k = 0; k < NUM_CH; k++) begin
        case (st_reg[k])
          tbls_pkg::CH_IDLE: begin
            if (fire_rise) begin
              dly_cnt_reg[k] <= cfg_reg[k].channel_delay;
              pat_addr_reg[k] <= start_addr(cfg_reg[k]);
              cyc_cnt_reg[k] <= '0;
              st_reg[k] <= tbls_pkg::CH_WAIT;
            end
          end
          tbls_pkg::CH_WAIT: begin
            if (!fire_on) begin
              st_reg[k] <= tbls_pkg::CH_IDLE;
            end else if (dly_cnt_reg[k] == '0) begin
              st_reg[k] <= tbls_pkg::CH_PLAY;
            end else begin
              dly_cnt_reg[k] <= dly_cnt_reg[k] - 1'b1;
            end
          end
          tbls_pkg::CH_PLAY: begin
            if (!fire_on) begin
              st_reg[k] <= tbls_pkg::CH_IDLE;
            end else if (eop_ch[k] && last_cyc[k]) begin
              st_reg[k] <= tbls_pkg::CH_DONE;
            end else if (eop_ch[k]) begin
              pat_addr_reg[k] <= start_addr(cfg_reg[k]);
              cyc_cnt_reg[k] <= cyc_cnt_reg[k] + 1'b1;
            end else begin
              pat_addr_reg[k] <= pat_addr_reg[k] + 1'b1;
            end
          end
          default: begin
            if (!fire_on) begin
              st_reg[k] <= tbls_pkg::CH_IDLE;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      current_level_reg <= tbls_pkg::CUR_2A10;
      tx_busy_reg <= 1'b0;
    end else begin
      current_level_reg <= current_dec;
      tx_busy_reg <= fire_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_strobe_low_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!fire_on && st_reg[0] != tbls_pkg::CH_IDLE) |=> st_reg[0] == tbls_pkg::CH_IDLE)
    else $error("channel kept running after strobe low");
  a_rise_loads_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fire_rise && st_reg[0] == tbls_pkg::CH_IDLE) |=>
      (st_reg[0] == tbls_pkg::CH_WAIT && pat_addr_reg[0] == start_addr(cfg_reg[0])))
    else $error("rising strobe did not start channel");
  a_sequential_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_reg[1] == tbls_pkg::CH_PLAY && fire_on && !eop_ch[1]) |=>
      pat_addr_reg[1] == $past(pat_addr_reg[1]) + 1'b1)
    else $error("pattern address not sequential");
  a_eop_reload_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_reg[0] == tbls_pkg::CH_PLAY && fire_on && eop_ch[0] && !last_cyc[0]) |=>
      (pat_addr_reg[0] == start_addr(cfg_reg[0]) && st_reg[0] == tbls_pkg::CH_PLAY))
    else $error("end symbol did not reload start");
  a_eop_never_driven: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_reg[2] == tbls_pkg::CH_PLAY && eop_ch[2]) |=> (!ch_drive_reg[2].pos && !ch_drive_reg[2].neg))
    else $error("end symbol reached the drive outputs");
  a_cwd_no_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lt_cfg_reg.continuous_wave_mode && st_reg[0] == tbls_pkg::CH_PLAY && fire_on) |=>
      st_reg[0] != tbls_pkg::CH_DONE)
    else $error("continuous wave ended on cycle count");
  a_apply_full_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    apply_reg |-> (byte_cnt_reg == cmd_len(apply_cmd_reg) && !addr_byte_reg[tbls_pkg::RW_BIT]))
    else $error("command applied before its full length");
  a_ln_fetch_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fetch_reg && fetch_cmd_reg == tbls_pkg::CMD_LINE1) |=>
      cfg_reg[0].channel_delay == $past(ln_data[0].channel_delay))
    else $error("line memory entry not loaded");
  a_current_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (fetch_reg && lt_data.drive_strength_sel_hi && !lt_data.drive_strength_sel_lo) |=> ##1
      current_level_reg == tbls_pkg::CUR_0A70)
    else $error("drive strength decode wrong");

  c_line1_applied: cover property (@(posedge clk_sys) apply_reg && apply_cmd_reg == tbls_pkg::CMD_LINE1);
  c_line2_applied: cover property (@(posedge clk_sys) apply_reg && apply_cmd_reg == tbls_pkg::CMD_LINE2);
  c_line3_applied: cover property (@(posedge clk_sys) apply_reg && apply_cmd_reg == tbls_pkg::CMD_LINE3);
  c_channel_done: cover property (@(posedge clk_sys) st_reg[0] == tbls_pkg::CH_DONE);

endmodule
`default_nettype wire

/* verif/tbls_spi_host.sv */
// SPI host model that ships line-setup command frames
`timescale 1ns/10ps
`default_nettype none
module tbls_spi_host (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one command per frame
  task automatic send(input logic [7:0] q[$]);
    #37 spi_cs_n = 1'b0;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) begin
        spi_mosi = q[i][b];
        #80 spi_sclk = 1'b1;
        #80 spi_sclk = 1'b0;
      end
    end
    #80 spi_cs_n = 1'b1;
    // Released data line shows the inverse of its last bit
    spi_mosi = ~spi_mosi;
  endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the line-setup block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0, rst_n = 1'b0, fire_strobe = 1'b0, five_level = 1'b0;
  wire logic sclk, cs_n, mosi;
  tbls_pkg::tbls_ln_entry_s [7:0] ln_data;
  tbls_pkg::tbls_lt_entry_s lt_data;
  logic [7:0][1:0] pat_sample;
  logic [10:0] lnp;
  logic [6:0] ltp;
  logic [7:0][12:0] pat_addr;
  tbls_pkg::tbls_drive_s [7:0] drv;
  tbls_pkg::tbls_current_e cur;
  logic busy, polarity_invert;
  int err_total = 0, total_checks = 0, cyc_no = 0, eop_n[8], t1[8], dly[8];
  logic [12:0] pa[8];
  logic [9:0] st[8];
  logic armed[8], tx[8], rx[8];
  always #5 clk_sys = ~clk_sys;
  tbls_spi_host host (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi));
  tbls_line_setup uut (.clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .fire_strobe(fire_strobe), .five_level(five_level), .ln_data(ln_data),
    .lt_data(lt_data), .pat_sample(pat_sample), .line_number_pointer_reg(lnp),
    .line_type_pointer_reg(ltp), .pat_addr_reg(pat_addr), .ch_drive_reg(drv),
    .current_level_reg(cur), .tx_busy_reg(busy));
  ////////////////////////////////////////////////////////////////////////
  // Pattern: offsets below 2+k%4 carry pulses, then the end symbol
  // Five-level pairs share one pattern so paired channels end together
  function automatic logic [1:0] smp(int k, logic [12:0] a);
    int o = a[2:0];
    int j = five_level ? k % 4 : k;
    return (o >= 2 + j % 4) ? 2'h3 : 2'((o + j) % 3);
  endfunction
  // Expected {pos,neg,clamp}
  function automatic logic [2:0] dec(int k, logic [1:0] s);
    if (!tx[k] || s == 2'h0) return 3'h1;
    return (s[1] ^ polarity_invert) ? 3'h4 : 3'h2;
  endfunction
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      ln_data[k].channel_delay = 13'((lnp + 3 * (five_level ? k % 4 : k)) % 16);
      ln_data[k].pattern_start_address = 10'(lnp + (five_level ? k % 4 : k));
      pat_sample[k] = smp(k, pat_addr[k]);
    end
  end
  assign lt_data = {8'(ltp % 3 + 1), ltp[6], ltp[1:0]};
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #1ms;
    err_total++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  // Playback monitor
  always @(posedge clk_sys) begin
    #1;
    cyc_no++;
    for (int k = 0; k < 8; k++) begin
      if (fire_strobe && armed[k] && pat_addr[k] !== pa[k]) begin
        if (smp(k, pa[k]) == 2'h3) begin
          check(pat_addr[k], {st[k], 3'h0});
          check({drv[k].pos, drv[k].neg}, 0);
        end else begin
          check(pat_addr[k], pa[k] + 1);
          check(drv[k][3:1], dec(k, smp(k, pa[k])));
          if (t1[k] < 0) t1[k] = cyc_no;
        end
        if (smp(k, pat_addr[k]) == 2'h3) eop_n[k]++;
      end
      armed[k] = armed[k] | (fire_strobe && pat_addr[k] === {st[k], 3'h0});
      pa[k] = pat_addr[k];
    end
  end
  task automatic frame(input logic [207:0] v, input int n);
    logic [7:0] q[$];
    for (int i = n - 1; i >= 0; i--) q.push_back(v[i*8 +: 8]);
    host.send(q);
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic run(input int hold, input int c, input logic w);
    for (int k = 0; k < 8; k++) begin
      armed[k] = 1'b0;
      t1[k] = -1;
      eop_n[k] = 0;
    end
    fire_strobe = 1'b1;
    repeat (4) @(negedge clk_sys);
    check(busy, 1);
    repeat (hold) @(negedge clk_sys);
    fire_strobe = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(busy, 0);
    for (int k = 0; k < 8; k++) begin
      check({drv[k].pos, drv[k].neg}, 0);
      check(drv[k].rx_on, rx[k]);
      check(t1[k] < 0, 0);
      check(t1[k] - t1[0], dly[k] - dly[0]);
      if (w) check(eop_n[k] > c, 1);
      else check(eop_n[k], c);
    end
    repeat (16) @(negedge clk_sys);
  endtask
  initial begin
    logic [207:0] v;
    logic [6:0] lt;
    logic [10:0] ln;
    void'($urandom(4));
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    check(cur, 4'h1);
    check({lnp, ltp, busy, drv[0]}, 4'h2);
    for (int i = 0; i < 4; i++) begin
      lt = {1'b0, 4'($urandom), 2'(i)};
      ln = 11'($urandom);
      polarity_invert = i[0];
      five_level = (i == 3);
      v = {176'h0, 1'b0, tbls_pkg::ADDR_LINE1, 5'h00, ln, lt, polarity_invert};
      frame(v, 4);
      check({lnp, ltp}, {ln, lt});
      check(cur, 4'h1 << i);
      for (int k = 0; k < 8; k++) begin
        dly[k] = (ln + 3 * (five_level ? k % 4 : k)) % 16;
        st[k] = 10'(ln + (five_level ? k % 4 : k));
        tx[k] = 1'b1;
        rx[k] = 1'b1;
      end
      run(100, lt % 3 + 1, 1'b0);
    end
    five_level = 1'b0;
    frame((v | (208'h1 << 31)) ^ (208'h7FF << 8), 4);
    check(lnp, ln);
    frame({v[207:8] ^ 200'h3F, v[7:0]} >> 8, 3);
    check({lnp, ltp}, {ln, lt});
    // line command two, channel 0 first
    lt = {1'b0, 6'($urandom)};
    polarity_invert = 1'($urandom);
    v = {1'b0, tbls_pkg::ADDR_LINE2, lt, polarity_invert, 192'h0};
    for (int k = 0; k < 8; k++) begin
      dly[k] = $urandom % 41;
      st[k] = 10'($urandom);
      tx[k] = 1'b1;
      rx[k] = 1'($urandom);
      v[191 - 24 * k -: 24] = {13'(dly[k]), st[k], rx[k]};
    end
    frame(v, 26);
    check(ltp, lt);
    run(100, lt % 3 + 1, 1'b0);
    // line command three, shared start, continuous wave
    lt = {1'b1, 6'($urandom)};
    polarity_invert = 1'b0;
    st[0] = 10'($urandom);
    v = {48'h0, 1'b0, tbls_pkg::ADDR_LINE3, lt, polarity_invert, 6'h00, st[0], 128'h0};
    for (int k = 0; k < 8; k++) begin
      dly[k] = $urandom % 41;
      st[k] = st[0];
      tx[k] = 1'($urandom);
      rx[k] = 1'($urandom);
      v[127 - 16 * k -: 16] = {1'b0, 13'(dly[k]), rx[k], tx[k]};
    end
    frame(v, 20);
    check(ltp, lt);
    run(120, lt % 3 + 1, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
